// ==== diag_interrupt_sequencer_defines.vh ====
// Offsets, field positions and fixed values of the diagnostic sequencer
`ifndef DIAG_INTERRUPT_SEQUENCER_DEFINES_VH
`define DIAG_INTERRUPT_SEQUENCER_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_SUMMARY_FLAGS 5'h00
`define OFS_MODULE_CLASS 5'h01
`define OFS_SUPPLY_FAULT 5'h02
`define OFS_LOST_INTERRUPT 5'h03
`define OFS_CHANNEL_TYPE 5'h04
`define OFS_BITS_PER_CHANNEL 5'h05
`define OFS_CHANNEL_COUNT 5'h06
`define OFS_GROUP_ERROR 5'h07
`define OFS_LOST_FIRST 5'h08
`define OFS_DIAG_CONFIG 5'h10
`define OFS_DIAG_STATUS 5'h11

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_MODULE_FAIL 0
`define BIT_EXT_ERROR 2
`define BIT_CHAN_ERROR 3
`define BIT_AUX_MISSING 4
`define BIT_CHAN_INFO 4
`define BIT_SUPPLY_OVERLOAD 4
`define BIT_PI_LOST 6
`define BIT_MORE_TYPES 7
`define BIT_CFG_ENABLE 0
`define BIT_STS_FAULT 0
`define BIT_STS_DIAG_BUSY 1
`define BIT_STS_PI_BUSY 2

// ----------------------------------------
// Fixed values and reset values
// ----------------------------------------
`define CLASS_ANALOG 4'h5
`define CLASS_DIGITAL 4'hf
`define CHANNEL_TYPE_DI 7'h70
`define BITS_PER_CHANNEL 8'h08
`define CHANNEL_COUNT 8'h08
`define OUTGOING_FILL 8'h00
`define RST_BYTE 8'h00

`endif

// ==== diag_interrupt_sequencer.v ====
// Diagnostic interrupt sequencer with diagnostic record store
//
// What this block does
// R1: Diagnostic interrupts are raised only while the global enable bit is set.
// R2: A process event recurring on the source being serviced raises a diagnostic.
// R3: An incoming diagnostic preempts the process interrupt being serviced.
// R4: During diagnostic handling new events are held pending, not delivered.
// R5: Held diagnostics go first in arrival order, then held process interrupts.
// R6: Process events on a channel with incoming diagnostic active are discarded.
// R7: When the causing process interrupt finishes, an outgoing diagnostic is raised.
// R8: Events on a channel between incoming and outgoing are dropped unstored.
// R9: Fault indicator lit from first incoming to last outgoing diagnostic.
// R10: Each diagnostic raised emits one log entry with cause and module address.
// R11: With diagnostics disabled the latest diagnostic event stays readable.
// R12: Summary bytes are valid in the store when the diagnostic is raised.
// R13: Byte 0 holds failure, external, channel, supply flags; other bits zero.
// R14: Byte 1 holds module class, digital 1111b, and channel-info bit 4.
// R15: Incoming byte 2 bit 4 flags internal supply overload; rest zero.
// R16: Incoming byte 3 bit 6 flags a lost process interrupt; rest zero.
// R17: Outgoing record keeps bytes 0 and 1, bytes 2 and 3 read 00h.
// R18: Extended record is four summary bytes plus twelve specific bytes.
// R19: Byte 4 bits 6 to 0 give channel type 70h, digital input.
// R20: Byte 4 bit 7 flags further channel types, zero here.
// R21: Byte 5 reports eight diagnostic bits per channel.
// R22: Byte 6 reports eight channels.
// R23: Byte 7 flags one error bit per channel group.
// R24: Bytes 8 to 15 flag lost sources on even bits; odd bits zero.
// R25: Record bytes live in a read-only byte store updated atomically.
`timescale 1ns/100ps
`include "diag_interrupt_sequencer_defines.vh"

module diag_interrupt_sequencer #(
    parameter [15:0] MODULE_ADDR = 16'h0000,
    parameter QAW = 4
) (
    input wire i_clk,
    input wire i_srst,
    input wire [4:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    input wire [31:0] i_pi_event,
    input wire i_module_fail,
    input wire i_ext_error,
    input wire i_aux_missing,
    input wire i_supply_overload,
    output reg o_pi_req,
    output reg [4:0] o_pi_source,
    input wire i_pi_done,
    output reg o_diag_req,
    output reg o_diag_outgoing,
    output reg [2:0] o_diag_channel,
    input wire i_diag_done,
    output reg o_log_valid,
    output reg [7:0] o_log_cause,
    output reg [15:0] o_log_addr,
    output reg o_fault_led
);

// ----------------------------------------
// Helpers
// ----------------------------------------
localparam QDEPTH = 1 << QAW;

// Lost flags of four sources sit on even bits
function [7:0] spread;
    input [3:0] b;
    begin
        spread = {1'b0, b[3], 1'b0, b[2], 1'b0, b[1], 1'b0, b[0]};
    end
endfunction

function [7:0] byte0;
    input dummy;
    begin
        byte0 = 8'h00;
        byte0[`BIT_MODULE_FAIL] = i_module_fail; // see R13
        byte0[`BIT_EXT_ERROR] = i_ext_error; // see R13
        byte0[`BIT_CHAN_ERROR] = 1'b1; // see R13
        byte0[`BIT_AUX_MISSING] = i_aux_missing; // see R13
    end
endfunction

// ----------------------------------------
// State
// ----------------------------------------
reg enable;
reg [7:0] store [0:15];
reg [31:0] pend;
reg [7:0] active;
reg [7:0] waiting;
reg [31:0] lost;
reg pi_busy;
reg [4:0] cur_src;
reg diag_busy;
reg [3:0] diag_cur;
reg [3:0] queue [0:QDEPTH-1];
reg [QAW-1:0] wr_ptr;
reg [QAW-1:0] rd_ptr;
reg [QAW:0] count;

reg [31:0] next_pend;
reg [7:0] next_active;
reg [7:0] next_waiting;
reg [31:0] next_lost;
reg next_pi_busy;
reg [4:0] next_cur_src;
reg next_diag_busy;
reg [3:0] next_diag_cur;
reg push;
reg [3:0] push_entry;
reg pop;
reg snap;
reg [3:0] snap_entry;
reg [31:0] snap_lost;
reg [7:0] snap_group;
reg [2:0] g;
reg launch;
integer s;

wire pi_done = i_pi_done & o_pi_req;
wire diag_done = i_diag_done & o_diag_req;
wire [2:0] cur_grp = cur_src[4:2];

// ----------------------------------------
// Sequencing
// ----------------------------------------
always @* begin
    next_pend = pend;
    next_active = active;
    next_waiting = waiting;
    next_lost = lost;
    next_pi_busy = pi_busy;
    next_cur_src = cur_src;
    next_diag_busy = diag_busy;
    next_diag_cur = diag_cur;
    push = 1'b0;
    push_entry = 4'h0;
    pop = 1'b0;
    snap = 1'b0;
    snap_entry = 4'h0;
    snap_lost = 32'h0;
    snap_group = 8'h00;
    g = 3'h0;
    launch = 1'b0;

    // Diagnostic handling finishes
    if (diag_done) begin
        next_diag_busy = 1'b0;
        if (diag_cur[3]) begin
            next_active[diag_cur[2:0]] = 1'b0; // see R9
            next_lost[{diag_cur[2:0], 2'b00} +: 4] = 4'h0;
        end
    end

    // The serviced process interrupt completes
    if (pi_done) begin
        next_pi_busy = 1'b0;
        if (waiting[cur_grp]) begin
            next_waiting[cur_grp] = 1'b0;
            if (enable) begin
                push = 1'b1; // see R7
                push_entry = {1'b1, cur_grp};
            end else begin
                // No outgoing message once disabled; the window closes quietly
                next_active[cur_grp] = 1'b0; // see R1, R9
                next_lost[{cur_grp, 2'b00} +: 4] = 4'h0;
            end
        end
    end

    // Diagnostics go first, one at a time, oldest first
    if (!diag_busy && count != 0) begin
        pop = 1'b1; // see R5
        next_diag_busy = 1'b1; // see R3
        next_diag_cur = queue[rd_ptr];
        snap = 1'b1; // see R12
        snap_entry = queue[rd_ptr];
        snap_lost = lost;
        snap_group = active;
    end

    // Process interrupts only when no diagnostic is running or held
    if (!pi_busy && !diag_busy && count == 0 && pend != 32'h0) begin
        launch = 1'b1; // see R4
        for (s = 31; s >= 0; s = s - 1) begin
            if (pend[s]) begin
                next_cur_src = s[4:0];
            end
        end
        next_pi_busy = 1'b1;
        next_pend[next_cur_src] = 1'b0;
    end

    // New process events; a set after the clear above wins
    for (s = 0; s < 32; s = s + 1) begin
        if (i_pi_event[s]) begin
            g = s[4:2];
            if (active[g]) begin
                // Dropped without storage
                next_pend[s] = next_pend[s]; // see R6, R8
            end else if (pi_busy && !pi_done && cur_src == s[4:0]) begin
                if (enable) begin
                    push = 1'b1; // see R1, R2
                    push_entry = {1'b0, g};
                    next_active[g] = 1'b1;
                    next_waiting[g] = 1'b1;
                    next_lost[s] = 1'b1;
                end else if (!snap) begin
                    snap = 1'b1; // see R11
                    snap_entry = {1'b0, g};
                    snap_lost = lost;
                    snap_lost[s] = 1'b1;
                    snap_group = active;
                    snap_group[g] = 1'b1;
                end
            end else begin
                next_pend[s] = 1'b1; // see R4
            end
        end
    end
end

// ----------------------------------------
// Registers
// ----------------------------------------
always @(posedge i_clk) begin
    if (i_srst) begin
        enable <= 1'b0;
        pend <= 32'h0;
        active <= 8'h00;
        waiting <= 8'h00;
        lost <= 32'h0;
        pi_busy <= 1'b0;
        cur_src <= 5'h00;
        diag_busy <= 1'b0;
        diag_cur <= 4'h0;
        wr_ptr <= {QAW{1'b0}};
        rd_ptr <= {QAW{1'b0}};
        count <= {(QAW+1){1'b0}};
        o_pi_req <= 1'b0;
        o_pi_source <= 5'h00;
        o_diag_req <= 1'b0;
        o_diag_outgoing <= 1'b0;
        o_diag_channel <= 3'h0;
        o_log_valid <= 1'b0;
        o_log_cause <= 8'h00;
        o_log_addr <= 16'h0000;
        o_fault_led <= 1'b0;
        o_rdata <= 8'h00;
    end else begin
        if (i_wr && i_addr == `OFS_DIAG_CONFIG) begin
            enable <= i_wdata[`BIT_CFG_ENABLE]; // see R1
        end
        pend <= next_pend;
        active <= next_active;
        waiting <= next_waiting;
        lost <= next_lost;
        pi_busy <= next_pi_busy;
        cur_src <= next_cur_src;
        diag_busy <= next_diag_busy;
        diag_cur <= next_diag_cur;
        if (push) begin
            queue[wr_ptr] <= push_entry;
            wr_ptr <= wr_ptr + 1'b1;
        end
        if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
        count <= count + {{QAW{1'b0}}, push} - {{QAW{1'b0}}, pop};
        // Preempted process interrupt is withdrawn until diagnostics end
        o_pi_req <= next_pi_busy & ~next_diag_busy & (count == 0) & ~push; // see R3
        o_pi_source <= next_cur_src;
        o_diag_req <= next_diag_busy;
        o_diag_outgoing <= next_diag_cur[3];
        o_diag_channel <= next_diag_cur[2:0];
        o_log_valid <= pop; // see R10
        o_log_cause <= byte0(1'b0);
        o_log_addr <= MODULE_ADDR;
        o_fault_led <= |next_active; // see R9
        o_rdata <= 8'h00;
        if (i_rd) begin
            if (i_addr[4] == 1'b0) begin
                o_rdata <= store[i_addr[3:0]]; // see R25
            end else if (i_addr == `OFS_DIAG_CONFIG) begin
                o_rdata <= {7'h00, enable};
            end else if (i_addr == `OFS_DIAG_STATUS) begin
                o_rdata <= {5'h00, pi_busy, diag_busy, o_fault_led};
            end
        end
    end
end

// ----------------------------------------
// Diagnostic record store
// ----------------------------------------
// All sixteen bytes change in one edge so a read never mixes two events
// One process writes the whole store so every byte has a single driver
wire [63:0] lost_image;
integer j;

genvar k;
generate
    for (k = 0; k < 8; k = k + 1) begin : lost_bytes
        assign lost_image[8*k +: 8] = snap_entry[3] ? `OUTGOING_FILL :
            spread(snap_lost[4*k +: 4]); // see R24
    end
endgenerate

always @(posedge i_clk) begin
    if (i_srst) begin
        for (j = 8; j < 16; j = j + 1) begin
            store[j] <= `RST_BYTE;
        end
        store[0] <= `RST_BYTE;
        store[1] <= `RST_BYTE;
        store[2] <= `RST_BYTE;
        store[3] <= `RST_BYTE;
        store[4] <= {1'b0, `CHANNEL_TYPE_DI};
        store[5] <= `BITS_PER_CHANNEL;
        store[6] <= `CHANNEL_COUNT;
        store[7] <= `RST_BYTE;
    end else if (snap) begin
        store[0] <= byte0(1'b0); // see R13
        store[1] <= {3'h0, 1'b1, `CLASS_DIGITAL}; // see R14
        if (snap_entry[3]) begin
            store[2] <= `OUTGOING_FILL; // see R17
            store[3] <= `OUTGOING_FILL; // see R17
            store[7] <= snap_group & ~(8'h01 << snap_entry[2:0]);
        end else begin
            store[2] <= {3'h0, i_supply_overload, 4'h0}; // see R15
            store[3] <= {1'b0, 1'b1, 6'h00}; // see R16
            store[7] <= snap_group; // see R23
        end
        store[4] <= {1'b0, `CHANNEL_TYPE_DI}; // see R18, R19, R20
        store[5] <= `BITS_PER_CHANNEL; // see R21
        store[6] <= `CHANNEL_COUNT; // see R22
        for (j = 0; j < 8; j = j + 1) begin
            store[8 + j] <= lost_image[8*j +: 8];
        end
    end
end

endmodule

// ==== diag_seq_sva.sv ====
// Port assertions for the diagnostic interrupt sequencer
`timescale 1ns/100ps
module diag_seq_sva #(
    parameter [15:0] MODULE_ADDR = 16'h0000
) (
    input wire i_clk,
    input wire i_srst,
    input wire i_rd,
    input wire [7:0] o_rdata,
    input wire o_pi_req,
    input wire i_pi_done,
    input wire o_diag_req,
    input wire o_diag_outgoing,
    input wire [2:0] o_diag_channel,
    input wire i_diag_done,
    input wire o_log_valid,
    input wire [7:0] o_log_cause,
    input wire [15:0] o_log_addr,
    input wire o_fault_led
);
    // ----
    // Diagnostic handshake steps
    // ----
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence s_diag_wait;
        o_diag_req && !i_diag_done;
    endsequence
    sequence s_diag_held;
        o_diag_req && $stable(o_diag_channel) && $stable(o_diag_outgoing);
    endsequence
    sequence s_diag_end;
        o_diag_req && i_diag_done;
    endsequence
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data outside answer cycle");
    a_no_overlap: assert property (!(o_pi_req && o_diag_req))
        else $error("process and diagnostic offered together");
    a_log_on_raise: assert property ($rose(o_diag_req) |-> o_log_valid)
        else $error("diagnostic raised without log entry");
    a_log_single: assert property (o_log_valid |=> !o_log_valid)
        else $error("log entry repeated");
    a_log_content: assert property (o_log_valid |-> o_log_addr == MODULE_ADDR
        && o_log_cause[7:5] == 3'b000 && !o_log_cause[1])
        else $error("log entry content wrong");
    a_fault_lit: assert property (o_diag_req && !o_diag_outgoing |-> o_fault_led)
        else $error("fault indicator dark during incoming");
    a_diag_hold: assert property (s_diag_wait |=> s_diag_held)
        else $error("diagnostic withdrawn or changed early");
    a_diag_end: assert property (s_diag_end |=> !o_diag_req)
        else $error("diagnostic stands after done");
    a_pi_hold: assert property (o_pi_req && !i_pi_done |=> o_pi_req || o_fault_led)
        else $error("process interrupt dropped without cause");
endmodule

bind diag_interrupt_sequencer diag_seq_sva #(.MODULE_ADDR(MODULE_ADDR)) i_diag_seq_sva (
    .i_clk, .i_srst, .i_rd, .o_rdata, .o_pi_req, .i_pi_done, .o_diag_req,
    .o_diag_outgoing, .o_diag_channel, .i_diag_done, .o_log_valid, .o_log_cause,
    .o_log_addr, .o_fault_led);

// ==== host_model.sv ====
// Behavioural host that services process and diagnostic interrupts
`timescale 1ns/100ps
module host_model (
    input wire i_clk,
    input wire i_srst,
    input wire [7:0] i_delay,
    input wire i_pi_req,
    input wire i_diag_req,
    output reg o_pi_done,
    output reg o_diag_done
);
    reg [7:0] pi_cnt;
    reg [7:0] diag_cnt;
    // A withdrawn request restarts the count, but done can still show in the cycle after the request falls
    always @(posedge i_clk) begin
        if (i_srst || !i_pi_req || o_pi_done) begin
            pi_cnt <= 8'h00;
            o_pi_done <= 1'b0;
        end else begin
            pi_cnt <= pi_cnt + 8'h01;
            o_pi_done <= (pi_cnt == i_delay);
        end
        if (i_srst || !i_diag_req || o_diag_done) begin
            diag_cnt <= 8'h00;
            o_diag_done <= 1'b0;
        end else begin
            diag_cnt <= diag_cnt + 8'h01;
            o_diag_done <= (diag_cnt == i_delay);
        end
    end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the diagnostic interrupt sequencer
`timescale 1ns/100ps
module tb_top;
    reg i_clk = 1'b0;
    reg i_srst = 1'b1;
    reg [4:0] i_addr = 5'h00;
    reg [7:0] i_wdata = 8'h00;
    reg i_wr = 1'b0;
    reg i_rd = 1'b0;
    reg [31:0] i_pi_event = 32'h0;
    reg i_module_fail = 1'b0;
    reg i_ext_error = 1'b0;
    reg i_aux_missing = 1'b0;
    reg i_supply_overload = 1'b0;
    reg [7:0] delay = 8'h03;
    reg [7:0] rnd = 8'h4c;
    wire [7:0] o_rdata, o_log_cause;
    wire [4:0] o_pi_source;
    wire [2:0] o_diag_channel;
    wire [15:0] o_log_addr;
    wire o_pi_req, i_pi_done, o_diag_req, o_diag_outgoing, i_diag_done, o_log_valid, o_fault_led;
    int error_cnt = 0;
    int samples_checked = 0;
    int s;
    int log_cnt = 0;

    always #5 i_clk = ~i_clk;
    always @(posedge i_clk)
        if (o_log_valid === 1'b1)
            log_cnt <= log_cnt + 1;

    diag_interrupt_sequencer i_diag_interrupt_sequencer (.i_clk, .i_srst, .i_addr, .i_wdata,
        .i_wr, .i_rd, .o_rdata, .i_pi_event, .i_module_fail, .i_ext_error, .i_aux_missing,
        .i_supply_overload, .o_pi_req, .o_pi_source, .i_pi_done, .o_diag_req,
        .o_diag_outgoing, .o_diag_channel, .i_diag_done, .o_log_valid, .o_log_cause,
        .o_log_addr, .o_fault_led);
    host_model i_host_model (.i_clk, .i_srst, .i_delay(delay), .i_pi_req(o_pi_req),
        .i_diag_req(o_diag_req), .o_pi_done(i_pi_done), .o_diag_done(i_diag_done));

    // ----
    // Helpers
    // ----
    function [7:0] lfsr(input [7:0] v);
        lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    // Flags come as {fail, ext, aux}; channel error is always set here
    function [7:0] b0_exp(input [2:0] f);
        b0_exp = {3'b000, f[0], 1'b1, f[1], 1'b0, f[2]};
    endfunction
    task wrap_up;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input [7:0] e, input [7:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task wr(input [4:0] a, input [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task rd(input [4:0] a, input [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk("rdata", e, o_rdata);
    endtask
    task pulse(input [4:0] src);
        @(posedge i_clk);
        i_pi_event <= 32'h1 << src;
        @(posedge i_clk);
        i_pi_event <= 32'h0;
    endtask
    task wait_for(input int sel, input logic v);
        int n;
        n = 0;
        while (((sel == 0) ? o_pi_req : o_diag_req) !== v) begin
            @(posedge i_clk);
            #1;
            n++;
            if (n > 300) begin
                chk("wait", 8'h01, 8'h00);
                wrap_up;
            end
        end
    endtask

    initial begin
        repeat (5) @(posedge i_clk);
        i_srst <= 1'b0;
        for (s = 0; s < 16; s++)
            rd(s[4:0], (s == 4) ? 8'h70 : (s == 5 || s == 6) ? 8'h08 : 8'h00);
        rd(5'h10, 8'h00);
        rd(5'h12, 8'h00);
        wr(5'h04, 8'hff);
        rd(5'h04, 8'h70);
        for (s = 0; s < 6; s++) begin
            rnd = lfsr(rnd);
            pulse(rnd[4:0]);
            wait_for(0, 1'b1);
            chk("pi source", {3'b000, rnd[4:0]}, {3'b000, o_pi_source});
            wait_for(0, 1'b0);
        end
        // Recurrence with diagnostics off: record only, no interrupt
        delay <= 8'd40;
        rnd = lfsr(rnd);
        {i_module_fail, i_ext_error, i_aux_missing} <= rnd[7:5];
        i_supply_overload <= 1'b1;
        pulse(rnd[4:0]);
        wait_for(0, 1'b1);
        pulse(rnd[4:0]);
        repeat (4) @(posedge i_clk);
        #1;
        chk("diag off", 8'h00, {7'h0, o_diag_req});
        rd(5'h00, b0_exp(rnd[7:5]));
        rd(5'h01, 8'h1f);
        rd(5'h02, 8'h10);
        rd(5'h03, 8'h40);
        rd(5'h08 + rnd[4:2], 8'h01 << {rnd[1:0], 1'b0});
        wait_for(0, 1'b0);
        wr(5'h10, 8'h01);
        rd(5'h10, 8'h01);
        pulse(5);
        wait_for(0, 1'b1);
        pulse(9);
        pulse(5);
        wait_for(1, 1'b1);
        chk("channel", 8'h01, {5'h0, o_diag_channel});
        chk("outgoing", 8'h00, {7'h0, o_diag_outgoing});
        chk("fault", 8'h01, {7'h0, o_fault_led});
        chk("log valid", 8'h01, {7'h0, o_log_valid});
        chk("log cause", b0_exp(rnd[7:5]), o_log_cause);
        pulse(20);
        pulse(6);
        rd(5'h03, 8'h40);
        chk("held", 8'h00, {7'h0, o_pi_req});
        rd(5'h11, 8'h07);
        rd(5'h07, 8'h02);
        rd(5'h09, 8'h04);
        wait_for(1, 1'b0);
        wait_for(0, 1'b1);
        chk("resume", 8'h05, {3'h0, o_pi_source});
        wait_for(1, 1'b1);
        chk("outgoing", 8'h01, {7'h0, o_diag_outgoing});
        rd(5'h02, 8'h00);
        rd(5'h03, 8'h00);
        wait_for(1, 1'b0);
        chk("fault", 8'h00, {7'h0, o_fault_led});
        wait_for(0, 1'b1);
        chk("order", 8'h09, {3'h0, o_pi_source});
        wait_for(0, 1'b0);
        wait_for(0, 1'b1);
        chk("order", 8'h14, {3'h0, o_pi_source});
        wait_for(0, 1'b0);
        repeat (60) @(posedge i_clk);
        #1;
        chk("dropped", 8'h00, {7'h0, o_pi_req});
        chk("log count", 8'h02, log_cnt[7:0]);
        wrap_up;
    end
endmodule
